// ===== rtl/mfm_consts.vh
`ifndef MFM_CONSTS_VH
`define MFM_CONSTS_VH
// Register offsets (byte addresses)
`define MFM_ADDR_CTRL      8'h00
`define MFM_ADDR_CFG       8'h04
`define MFM_ADDR_SUMMARY   8'h08
`define MFM_ADDR_DETAIL    8'h0c
`define MFM_ADDR_LIVE      8'h10
// Control register fields
`define MFM_CTRL_CLR_BIT   0
// Config register fields
`define MFM_CFG_OVEN_BIT   0
`define MFM_CFG_OVSEL_BIT  1
`define MFM_CFG_MODE_LSB   2
`define MFM_CFG_LVL_BIT    4
`define MFM_CFG_DEG_LSB    5
`define MFM_CFG_WREP_BIT   7
`define MFM_CFG_RESET      8'h00
// Response codes
`define MFM_RESP_LATCH     2'h0
`define MFM_RESP_RETRY     2'h1
`define MFM_RESP_REPORT    2'h2
`define MFM_RESP_OFF       2'h3
// Timing
`define MFM_CLK_MHZ        25
`define MFM_DEG_HW_NS      600
`define MFM_DEG_HW_CYC     ((`MFM_DEG_HW_NS*`MFM_CLK_MHZ+999)/1000)
`define MFM_RETRY_US       5000
`define MFM_RETRY_CYC      (`MFM_RETRY_US*`MFM_CLK_MHZ)
`define MFM_BKRETRY_US     5000
`define MFM_BKRETRY_CYC    (`MFM_BKRETRY_US*`MFM_CLK_MHZ)
`define MFM_RST_MAX_US     40
`define MFM_RST_MAX_CYC    (`MFM_RST_MAX_US*`MFM_CLK_MHZ)
`endif

// ===== rtl/mfm_fault_manager.v
// Added by the designer: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`include "mfm_consts.vh"
module mfm_fault_manager #(
   parameter SERIAL_VARIANT = 1,
   parameter RETRY_CYC      = `MFM_RETRY_CYC,
   parameter BKRETRY_CYC    = `MFM_BKRETRY_CYC,
   parameter RST_MAX_CYC    = `MFM_RST_MAX_CYC
) (
   // Clock and reset
   input  wire       clk,
   input  wire       nrst,
   // Register port
   input  wire [7:0] addr,
   input  wire [7:0] wdata,
   input  wire       wr,
   input  wire       rd,
   output reg  [7:0] rdata,
   // Comparator indications
   input  wire       supply_uv,
   input  wire       ldo_uv,
   input  wire       buck_undervolt_flag,
   input  wire       pump_uv,
   input  wire       ov_20v,
   input  wire       ov_32v,
   input  wire       ov_34v,
   input  wire [5:0] oc_hi_lvl,
   input  wire [5:0] oc_lo_lvl,
   input  wire       buck_oc,
   input  wire       temp_warn,
   input  wire       temp_warn_hys,
   input  wire       temp_fet_sd,
   input  wire       sleep_control_pin,
   // Outputs
   output reg        bridge_en,
   output reg        pump_en,
   output reg        logic_en,
   output reg        buck_en,
   output reg        fault_out_pin_n
);
   // ----------------------------------------------------------------
   // Configuration and clear
   // ----------------------------------------------------------------
   reg  [7:0]  cfg_q;         // Configuration byte
   reg         supply_power_on_flag_q;        // supply_power_on_flag
   reg         bk_uv_q;       // buck_undervolt_flag
   reg         bk_oc_q;       // buck_overcurrent_flag
   reg         cp_uv_q;       // pump_undervolt_flag
   reg         ov_q;          // overvolt_flag
   reg         oc_q;          // overcurrent_flag
   reg         otw_q;         // thermal_warning_flag
   reg         ots_q;         // thermal_shutdown_flag
   reg  [5:0]  oc_sw_q;       // Per-switch overcurrent flags
   // Overcurrent response state
   reg         oc_hold_q;     // Latched shutdown
   reg         oc_retry_q;    // Retry wait
   reg         oc_rep_q;      // Report only
   reg  [31:0] retry_cnt_q;   // Retry countdown
   // Buck retry and warning pin state
   reg         bk_retry_q;
   reg  [31:0] bk_cnt_q;
   reg         otw_pin_q;
   // Sleep pin pulse detector
   reg         slp_q;         // Pin level one cycle ago
   reg  [15:0] slp_cnt_q;     // Low-phase length in cycles
   reg         pulse_clr_q;   // Valid reset pulse seen

   // ----------------------------------------------------------------
   // Configuration decode
   // ----------------------------------------------------------------
   // Pin variant has protection on, fixed response and fixed deglitch
   wire        ov_en   = SERIAL_VARIANT ? cfg_q[`MFM_CFG_OVEN_BIT] : 1'b1;
   wire [1:0]  mode    = SERIAL_VARIANT ?
                         cfg_q[`MFM_CFG_MODE_LSB+1:`MFM_CFG_MODE_LSB] :
                         `MFM_RESP_LATCH;
   wire        wrep    = cfg_q[`MFM_CFG_WREP_BIT];
   // Clear is a single write cycle; the sleep pulse is a second source
   wire        cmd_clr = wr && (addr == `MFM_ADDR_CTRL) &&
                         wdata[`MFM_CTRL_CLR_BIT];
   wire        clr     = cmd_clr | pulse_clr_q;
   wire        uvlo    = supply_uv | ldo_uv;
   // OV threshold selection
   wire        ov_raw  = SERIAL_VARIANT ?
                         (cfg_q[`MFM_CFG_OVSEL_BIT] ? ov_32v : ov_20v) :
                         ov_34v;
   wire        ov_act  = ov_en & ov_raw;
   // Level select per switch
   wire [5:0]  oc_in   = (SERIAL_VARIANT && cfg_q[`MFM_CFG_LVL_BIT]) ?
                         oc_hi_lvl : oc_lo_lvl;
   // Deglitch length in cycles
   // Fixed pin-variant limit must fit the four-bit counter below
   localparam integer DEG_HW_LIM = `MFM_DEG_HW_CYC - 1;
   wire [1:0]  deg_sel = cfg_q[`MFM_CFG_DEG_LSB+1:`MFM_CFG_DEG_LSB];
   wire [3:0]  deg_lim = SERIAL_VARIANT ? {2'h0, deg_sel} :
                         DEG_HW_LIM[3:0];
   wire [5:0]  oc_det;
   wire        oc_evt  = |oc_det && (mode != `MFM_RESP_OFF);
   wire        oc_live = |oc_in;

   // ----------------------------------------------------------------
   // Overcurrent deglitch per switch
   // ----------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < 6; g = g + 1) begin : g_deg
         // Cycles spent above threshold, saturating
         reg [3:0] cnt_q;
         // Count while above threshold; event once count passes limit
         always @(posedge clk or negedge nrst) begin
            if (!nrst) begin
               cnt_q <= 4'h0;
            end else if (!oc_in[g] || uvlo) begin
               cnt_q <= 4'h0;
            end else if (cnt_q != 4'hf) begin
               cnt_q <= cnt_q + 4'h1;
            end
         end
         assign oc_det[g] = oc_in[g] && (cnt_q > deg_lim);
      end
   endgenerate

   // ----------------------------------------------------------------
   // Sleep pin reset pulse detection
   // ----------------------------------------------------------------
   // Low phase no longer than window counts as fault clear
   // A long low phase is a sleep request, not a clear; the counter
   // saturates so a very long low phase never wraps into a short one
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         slp_q       <= 1'b1;
         slp_cnt_q   <= 16'h0000;
         pulse_clr_q <= 1'b0;
      end else begin
         slp_q       <= sleep_control_pin;
         pulse_clr_q <= sleep_control_pin && !slp_q &&
                        (slp_cnt_q <= RST_MAX_CYC[15:0]);
         if (sleep_control_pin) begin
            slp_cnt_q <= 16'h0000;
         end else if (slp_cnt_q != 16'hffff) begin
            slp_cnt_q <= slp_cnt_q + 16'h0001;
         end
      end
   end

   // ----------------------------------------------------------------
   // Configuration register
   // ----------------------------------------------------------------
   // Whole byte written at once; unmapped writes fall through
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cfg_q <= `MFM_CFG_RESET;
      end else if (wr && addr == `MFM_ADDR_CFG) begin
         cfg_q <= wdata;
      end
   end

   // ----------------------------------------------------------------
   // Sticky flags: a present cause wins over clear
   // ----------------------------------------------------------------
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         supply_power_on_flag_q  <= 1'b0;
         bk_uv_q <= 1'b0;
         cp_uv_q <= 1'b0;
         ov_q    <= 1'b0;
         oc_q    <= 1'b0;
         oc_sw_q <= 6'h00;
         otw_q   <= 1'b0;
         ots_q   <= 1'b0;
      end else begin
         // Power-on flag low after recovery until clear
         if (uvlo) begin
            supply_power_on_flag_q <= 1'b0;
         end else if (clr) begin
            supply_power_on_flag_q <= 1'b1;
         end
         // Buck undervoltage sticky
         if (buck_undervolt_flag) begin
            bk_uv_q <= 1'b1;
         end else if (clr) begin
            bk_uv_q <= 1'b0;
         end
         // Pump undervoltage sticky, always enabled
         if (pump_uv) begin
            cp_uv_q <= 1'b1;
         end else if (clr) begin
            cp_uv_q <= 1'b0;
         end
         // Overvoltage sticky, only while protection is enabled
         if (ov_act) begin
            ov_q <= 1'b1;
         end else if (clr) begin
            ov_q <= 1'b0;
         end
         // Overcurrent flags
         if (oc_evt) begin
            oc_q    <= 1'b1;
            oc_sw_q <= oc_sw_q | oc_det;
         end else if (clr && !oc_live) begin
            oc_q    <= 1'b0;
            oc_sw_q <= 6'h00;
         end
         // Warning clears only below trip point
         if (temp_warn) begin
            otw_q <= 1'b1;
         end else if (clr) begin
            otw_q <= 1'b0;
         end
         // Switch overtemperature sticky, cannot be disabled
         if (temp_fet_sd) begin
            ots_q <= 1'b1;
         end else if (clr) begin
            ots_q <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Overcurrent response and retry timers
   // ----------------------------------------------------------------
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         oc_hold_q   <= 1'b0;
         oc_retry_q  <= 1'b0;
         oc_rep_q    <= 1'b0;
         retry_cnt_q <= 32'h0;
         bk_retry_q  <= 1'b0;
         bk_oc_q     <= 1'b0;
         bk_cnt_q    <= 32'h0;
         otw_pin_q   <= 1'b0;
      end else begin
         // Latched shutdown until cleared after recovery
         if (oc_evt && mode == `MFM_RESP_LATCH) begin
            oc_hold_q <= 1'b1;
         end else if (clr && !oc_live) begin
            oc_hold_q <= 1'b0;
         end
         // Report only
         if (oc_evt && mode == `MFM_RESP_REPORT) begin
            oc_rep_q <= 1'b1;
         end else if (clr && !oc_live) begin
            oc_rep_q <= 1'b0;
         end
         // Automatic retry
         // Countdown reloads while the event persists
         if (oc_evt && mode == `MFM_RESP_RETRY) begin
            oc_retry_q  <= 1'b1;
            retry_cnt_q <= RETRY_CYC;
         end else if (oc_retry_q) begin
            if (retry_cnt_q <= 32'h1) begin
               oc_retry_q <= 1'b0;
            end
            retry_cnt_q <= retry_cnt_q - 32'h1;
         end
         // Buck overcurrent retry; flag held for the interval
         // Buck overcurrent arrives already deglitched
         if (buck_oc && !bk_retry_q) begin
            bk_retry_q <= 1'b1;
            bk_oc_q    <= 1'b1;
            bk_cnt_q   <= BKRETRY_CYC;
         end else if (bk_retry_q) begin
            if (bk_cnt_q <= 32'h1) begin
               bk_retry_q <= 1'b0;
               bk_oc_q    <= 1'b0;
            end
            bk_cnt_q <= bk_cnt_q - 32'h1;
         end
         // Warning on pin until below hysteresis point
         if (wrep && temp_warn) begin
            otw_pin_q <= 1'b1;
         end else if (!wrep || !temp_warn_hys) begin
            otw_pin_q <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Enables and fault pin
   // ----------------------------------------------------------------
   // Bridge stop causes held by the overcurrent response
   wire oc_stop  = oc_hold_q | oc_retry_q;
   wire bridge_d = !uvlo && !pump_uv && !ov_act && !oc_stop &&
                   !temp_fet_sd;
   // Live causes pull the fault pin low, except supply_uv alone
   wire fault_d  = buck_undervolt_flag     |
                   ldo_uv      |
                   pump_uv     |
                   ov_act      |
                   oc_stop     |
                   oc_rep_q    |
                   bk_retry_q  |
                   temp_fet_sd |
                   otw_pin_q;
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         bridge_en       <= 1'b0;
         pump_en         <= 1'b0;
         logic_en        <= 1'b0;
         buck_en         <= 1'b0;
         fault_out_pin_n <= 1'b1;
      end else begin
         // Bridge off for any stopping cause
         bridge_en       <= bridge_d;
         // Pump off on undervoltage lockout and switch overheat
         pump_en         <= !uvlo && !temp_fet_sd;
         // Controller off only on undervoltage lockout
         logic_en        <= !uvlo;
         // Buck off on its own faults, on overvoltage and on switch overheat, not on undervoltage lockout
         buck_en         <= !buck_undervolt_flag && !bk_retry_q && !ov_act &&
                            !temp_fet_sd;
         // Fault pin is active low
         fault_out_pin_n <= !fault_d;
      end
   end

   // ----------------------------------------------------------------
   // Read port
   // ----------------------------------------------------------------
   // Global fault: every latched cause except the warning
   wire gfault = bk_uv_q |
                 bk_oc_q |
                 cp_uv_q |
                 ov_q    |
                 oc_q    |
                 ots_q;
   reg  [7:0] rd_d;
   // Summary: fault, power-on, thermal, buck, overvoltage, overcurrent,
   //          pump undervoltage, spare
   // Detail:  buck overcurrent, buck undervoltage, warning, shutdown
   // Live:    per-switch overcurrent flags
   // Register select
   always @* begin
      case (addr)
         `MFM_ADDR_CFG:     rd_d = cfg_q;
         `MFM_ADDR_SUMMARY: rd_d = {gfault,            // Bit 7
                                    supply_power_on_flag_q,            // Bit 6
                                    otw_q | ots_q,     // Bit 5
                                    bk_uv_q | bk_oc_q, // Bit 4
                                    ov_q,              // Bit 3
                                    oc_q,              // Bit 2
                                    cp_uv_q,           // Bit 1
                                    1'b0};             // Bit 0 spare
         `MFM_ADDR_DETAIL:  rd_d = {bk_oc_q, bk_uv_q, otw_q, ots_q,
                                    4'h0};
         `MFM_ADDR_LIVE:    rd_d = {2'h0, oc_sw_q};
         default:           rd_d = 8'h00;
      endcase
   end
   // Read data stand only in the cycle after the read strobe
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rdata <= 8'h00;
      end else begin
         rdata <= rd ? rd_d : 8'h00;
      end
   end
endmodule // mfm_fault_manager

// ===== verification/mfm_fault_manager_sva.sv
`timescale 1ns/1ps
module mfm_fault_manager_sva (
   // Clock and reset
   input wire       clk,
   input wire       nrst,
   // Register port
   input wire       rd,
   input wire [7:0] rdata,
   // Comparators
   input wire       supply_uv,
   input wire       ldo_uv,
   input wire       buck_undervolt_flag,
   input wire       pump_uv,
   input wire       buck_oc,
   input wire       temp_fet_sd,
   input wire       sleep_control_pin,
   // Outputs
   input wire       bridge_en,
   input wire       pump_en,
   input wire       logic_en,
   input wire       buck_en,
   input wire       fault_out_pin_n
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);
   // ----
   // Shutdown and recovery
   // ----
   a_supply_off: assert property
      (supply_uv |=> !bridge_en && !pump_en && !logic_en)
      else $error("supply low left a stage on");
   a_ldo_off: assert property
      (ldo_uv |=> !bridge_en && !pump_en && !logic_en)
      else $error("regulator low left a stage on");
   a_logic_back: assert property
      (!supply_uv && !ldo_uv && sleep_control_pin |=> logic_en)
      else $error("controller not resumed");
   a_buck_undervolt_flag: assert property
      (buck_undervolt_flag && !supply_uv && !ldo_uv |=> !buck_en && !fault_out_pin_n)
      else $error("buck low not handled");
   a_pump_uv: assert property
      (pump_uv |=> !bridge_en && !fault_out_pin_n)
      else $error("pump low not handled");
   a_fet_hot: assert property
      (temp_fet_sd |=> !bridge_en && !pump_en && !fault_out_pin_n)
      else $error("switch overheat not handled");
   a_buck_retry: assert property
      ($rose(buck_oc) |-> ##2 !buck_en [*8])
      else $error("buck restarted too early");
   a_rdata_idle: assert property
      (!rd |=> rdata == 8'h00)
      else $error("read data outside read slot");
endmodule // mfm_fault_manager_sva
bind mfm_fault_manager mfm_fault_manager_sva mfm_fault_manager_sva_i (
   .clk(clk), .nrst(nrst), .rd(rd), .rdata(rdata), .supply_uv(supply_uv),
   .ldo_uv(ldo_uv), .buck_undervolt_flag(buck_undervolt_flag), .pump_uv(pump_uv),
   .buck_oc(buck_oc), .temp_fet_sd(temp_fet_sd),
   .sleep_control_pin(sleep_control_pin), .bridge_en(bridge_en),
   .pump_en(pump_en), .logic_en(logic_en), .buck_en(buck_en),
   .fault_out_pin_n(fault_out_pin_n));

// ===== verification/mfm_host_model.sv
`timescale 1ns/1ps
module mfm_host_model #(
   parameter LOW_CYC = 5
) (
   // Clock and request
   input  wire  clk,
   input  wire  go,
   // Sleep pin
   output logic sleep_control_pin
);
   // High-low-high pulse, low phase short enough to avoid full sleep
   initial sleep_control_pin = 1'b1;
   always @(posedge clk) begin
      if (go) begin
         sleep_control_pin <= 1'b0;
         repeat (LOW_CYC) @(posedge clk);
         sleep_control_pin <= 1'b1;
      end
   end
endmodule // mfm_host_model

// ===== verification/mfm_fault_manager_test.sv
`timescale 1ns/1ps
`include "mfm_consts.vh"
module mfm_fault_manager_test;
   logic       clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0;
   logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
   logic       s_uv = 1'b0, l_uv = 1'b0, b_uv = 1'b0, p_uv = 1'b0;
   logic       o20 = 1'b0, o32 = 1'b0, b_oc = 1'b0, go = 1'b0;
   logic       tw = 1'b0, th = 1'b0, tf = 1'b0, slp;
   logic [5:0] oc = 6'h00, oc_hi = 6'h00;
   logic       br, pu, lg, bk, fo_n;
   int         bad_count = 0, tests_run = 0;
   // Clock
   always #20 clk = ~clk;
   mfm_fault_manager #(.SERIAL_VARIANT(1), .RETRY_CYC(30),
      .BKRETRY_CYC(20), .RST_MAX_CYC(10)) mfm_fault_manager_i (
      .clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(rd), .rdata(rdata), .supply_uv(s_uv), .ldo_uv(l_uv),
      .buck_undervolt_flag(b_uv), .pump_uv(p_uv), .ov_20v(o20), .ov_32v(o32),
      .ov_34v(o32), .oc_hi_lvl(oc_hi), .oc_lo_lvl(oc), .buck_oc(b_oc),
      .temp_warn(tw), .temp_warn_hys(th), .temp_fet_sd(tf),
      .sleep_control_pin(slp), .bridge_en(br), .pump_en(pu),
      .logic_en(lg), .buck_en(bk), .fault_out_pin_n(fo_n));
   mfm_host_model #(.LOW_CYC(5)) mfm_host_model_i (
      .clk(clk), .go(go), .sleep_control_pin(slp));
   // ----
   // Tasks
   // ----
   task automatic chk(string n, logic [7:0] e, logic [7:0] g);
      tests_run++;
      if (g !== e) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wreg(logic [7:0] a, logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rreg(logic [7:0] a, logic [7:0] m, logic [7:0] e,
                       string n);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk(n, e, rdata & m);
   endtask
   task automatic settle(int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // Enables and pin as {bridge, pump, logic, buck, pin}
   task automatic outs(logic [4:0] m, logic [4:0] e, string n);
      settle(3);
      chk(n, {3'h0, e}, {3'h0, {br, pu, lg, bk, fo_n} & m});
   endtask
   task automatic clr();
      wreg(`MFM_ADDR_CTRL, 8'h01);
   endtask
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // ----
   // Tests
   // ----
   initial begin
      repeat (5) @(posedge clk);
      nrst <= 1'b1;
      rreg(`MFM_ADDR_SUMMARY, 8'hff, 8'h00, "summary reset");
      rreg(`MFM_ADDR_CFG, 8'hff, `MFM_CFG_RESET, "cfg reset");
      rreg(8'h20, 8'hff, 8'h00, "unmapped read");
      clr();
      for (int i = 0; i < 2; i++) begin
         {l_uv, s_uv} <= (i == 0) ? 2'h1 : 2'h2;
         outs(5'h1c, 5'h00, "uv off");
         {l_uv, s_uv} <= 2'h0;
         outs(5'h1c, 5'h1c, "uv resume");
         rreg(`MFM_ADDR_SUMMARY, 8'h40, 8'h00, "power-on low");
         clr();
         rreg(`MFM_ADDR_SUMMARY, 8'h40, 8'h40, "power-on set");
      end
      $display("undervoltage done");
      b_uv <= 1'b1;
      outs(5'h1f, 5'h1c, "buck_undervolt_flag");
      rreg(`MFM_ADDR_SUMMARY, 8'h90, 8'h90, "buck flags");
      b_uv <= 1'b0;
      outs(5'h1f, 5'h1f, "buck back");
      rreg(`MFM_ADDR_DETAIL, 8'h40, 8'h40, "buck_undervolt_flag sticky");
      clr();
      rreg(`MFM_ADDR_SUMMARY, 8'h90, 8'h00, "buck cleared");
      p_uv <= 1'b1;
      outs(5'h11, 5'h00, "pump uv");
      p_uv <= 1'b0;
      outs(5'h11, 5'h11, "pump back");
      rreg(`MFM_ADDR_SUMMARY, 8'h02, 8'h02, "pump sticky");
      @(posedge clk);
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      settle(12);
      rreg(`MFM_ADDR_SUMMARY, 8'h02, 8'h00, "sleep pulse");
      $display("buck and pump done");
      o32 <= 1'b1;
      outs(5'h11, 5'h11, "ov disabled");
      wreg(`MFM_ADDR_CFG, 8'h03);
      outs(5'h11, 5'h00, "ov 32");
      {o32, o20} <= 2'h1;
      outs(5'h11, 5'h11, "ov 20 ignored");
      wreg(`MFM_ADDR_CFG, 8'h01);
      outs(5'h11, 5'h00, "ov 20");
      o20 <= 1'b0;
      outs(5'h11, 5'h11, "ov resume");
      rreg(`MFM_ADDR_SUMMARY, 8'h08, 8'h08, "ov sticky");
      clr();
      for (int m = 0; m < 4; m++) begin
         wreg(`MFM_ADDR_CFG, {4'h0, m[1:0], 2'h0});
         oc <= 6'h01;
         for (int i = 0; i < 200 && fo_n !== 1'b0; i++) @(posedge clk);
         settle(2);
         chk("oc hit", {6'h0, m[1], m == 3}, {6'h0, br, fo_n});
         oc <= 6'h00;
         settle(45);
         chk("oc after", {6'h0, m != 0, m[0]}, {6'h0, br, fo_n});
         rreg(`MFM_ADDR_SUMMARY, 8'h04, {5'h0, m != 3, 2'h0},
              "oc flag");
         rreg(`MFM_ADDR_LIVE, 8'h3f, (m != 3) ? 8'h01 : 8'h00,
              "oc switch");
         clr();
         outs(5'h11, 5'h11, "oc cleared");
      end
      wreg(`MFM_ADDR_CFG, 8'h70);
      oc <= 6'h02;
      outs(5'h01, 5'h01, "level low ignored");
      oc_hi <= 6'h02;
      outs(5'h01, 5'h01, "deglitch hold");
      outs(5'h01, 5'h00, "deglitch trip");
      {oc_hi, oc} <= 12'h000;
      clr();
      outs(5'h11, 5'h11, "level cleared");
      $display("overcurrent done");
      b_oc <= 1'b1;
      outs(5'h03, 5'h00, "buck oc");
      rreg(`MFM_ADDR_DETAIL, 8'h80, 8'h80, "buck oc flag");
      b_oc <= 1'b0;
      settle(30);
      outs(5'h03, 5'h03, "buck retry");
      {tw, th} <= 2'h3;
      outs(5'h1f, 5'h1f, "warn quiet");
      rreg(`MFM_ADDR_SUMMARY, 8'h20, 8'h20, "warn summary");
      wreg(`MFM_ADDR_CFG, 8'h80);
      outs(5'h01, 5'h00, "warn pin");
      clr();
      rreg(`MFM_ADDR_DETAIL, 8'h20, 8'h20, "warn held");
      tw <= 1'b0;
      outs(5'h01, 5'h00, "hysteresis");
      th <= 1'b0;
      outs(5'h01, 5'h01, "warn release");
      clr();
      rreg(`MFM_ADDR_DETAIL, 8'h20, 8'h00, "warn cleared");
      tf <= 1'b1;
      outs(5'h1d, 5'h04, "fet hot");
      tf <= 1'b0;
      outs(5'h1d, 5'h1d, "fet cool");
      rreg(`MFM_ADDR_DETAIL, 8'h10, 8'h10, "ots sticky");
      clr();
      rreg(`MFM_ADDR_DETAIL, 8'h10, 8'h00, "ots cleared");
      $display("thermal done");
      end_of_test();
   end
   // Watchdog
   initial begin
      #(40 * 30000);
      bad_count++;
      end_of_test();
   end
endmodule // mfm_fault_manager_test
